// *** rtl/dnac_pkg.sv ***
package dnac_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and self-timer defaults
   localparam int unsigned CLK_PERIOD_NS      = 8;        // core clock period
   localparam int unsigned DEF_ERASE_TIME_NS  = 2000000;  // erase phase time
   localparam int unsigned DEF_PROG_TIME_NS   = 2000000;  // program phase time

   ////////////////////////////////////////////////////////////////////////////
   // unlock key values
   localparam logic [7:0]  KEY_FIRST          = 8'h55;    // first key byte
   localparam logic [7:0]  KEY_SECOND         = 8'hAA;    // second key byte

   ////////////////////////////////////////////////////////////////////////////
   // nvm_control field positions
   localparam int unsigned CTL_PGM_SEL        = 7;        // program space
   localparam int unsigned CTL_CFG_SEL        = 6;        // config space
   localparam int unsigned CTL_ROW_ERASE      = 4;        // row erase enable
   localparam int unsigned CTL_ABORT          = 3;        // write abort flag
   localparam int unsigned CTL_WRITE_ENABLE_GATE           = 2;        // write enable gate
   localparam int unsigned CTL_WR             = 1;        // write start
   localparam int unsigned CTL_RD             = 0;        // read start

   ////////////////////////////////////////////////////////////////////////////
   // reset and erase values
   localparam logic [7:0]  RST_BYTE           = 8'h00;    // data and address
   localparam logic [7:0]  ERASED_BYTE        = 8'hFF;    // erased cell value
   localparam logic        RST_BIT            = 1'b0;     // control bits

   ////////////////////////////////////////////////////////////////////////////
   // enumerations
   typedef enum logic [1:0]
   {
      SEL_KEY  = 2'b00,                                   // unlock_key_port
      SEL_CTL  = 2'b01,                                   // nvm_control
      SEL_DATA = 2'b10,                                   // nvm_data_byte
      SEL_ADDR = 2'b11                                    // nvm_address_byte
   } dnac_sel_t;

   typedef enum logic [1:0]
   {
      KEY_IDLE  = 2'b00,                                  // nothing seen
      KEY_HALF  = 2'b01,                                  // first key seen
      KEY_ARMED = 2'b10                                   // both keys seen
   } dnac_key_t;

   typedef enum logic [1:0]
   {
      PH_IDLE  = 2'b00,                                   // no operation
      PH_ERASE = 2'b01,                                   // erasing cell
      PH_PROG  = 2'b10                                    // programming cell
   } dnac_phase_t;

   ////////////////////////////////////////////////////////////////////////////
   // time in ns to whole core cycles, rounded up, at least one
   function automatic int unsigned dnac_ns_to_cyc(input int unsigned ns);
      int unsigned cyc;
      cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (cyc == 0) ? 1 : cyc;
   endfunction

endpackage // dnac_pkg

// *** rtl/dnac_arr_if.sv ***
interface dnac_arr_if;

   logic [7:0] addr;       // array byte address
   logic [7:0] wdata;      // byte to program
   logic       to_array;   // operation targets the data array
   logic       start;      // one-cycle launch of erase then program
   logic [7:0] rdata;      // array byte at addr
   logic       done;       // one-cycle completion pulse

   // controller side
   modport ctl (output addr, output wdata, output to_array, output start,
                input rdata, input done);

   // array side
   modport arr (input addr, input wdata, input to_array, input start,
                output rdata, output done);

endinterface // dnac_arr_if

// *** rtl/dnac_array.sv ***
module dnac_array
   import dnac_pkg::*;
#(
   parameter int unsigned ERASE_CYC = 1,   // erase phase cycles
   parameter int unsigned PROG_CYC  = 1    // program phase cycles
)
(
   // clock, reset, enable
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   input  wire logic  ce_i,
   // controller link
   dnac_arr_if.arr    arr
);

   ////////////////////////////////////////////////////////////////////////////
   // storage and timer state
   logic [7:0]  mem_q [256];   // nonvolatile cells, not reset
   dnac_phase_t phase_q;       // self-timer phase
   logic [31:0] cnt_q;         // cycles left in phase
   logic        done_q;        // completion pulse

   // read port is plain combinational, one cycle read
   assign arr.rdata = mem_q[arr.addr];
   assign arr.done  = done_q;

   ////////////////////////////////////////////////////////////////////////////
   // self-timer: erase phase, then program phase
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         // any reset cuts the operation short
         phase_q <= PH_IDLE;
         cnt_q   <= 32'h0000_0000;
         done_q  <= RST_BIT;
      end
      else if (ce_i)
      begin
         done_q <= RST_BIT;
         unique case (phase_q)
            PH_IDLE:
            begin
               if (arr.start)
               begin
                  phase_q <= PH_ERASE;
                  cnt_q   <= 32'(ERASE_CYC - 1);
               end
            end
            PH_ERASE:
            begin
               if (cnt_q == 32'h0000_0000)
               begin
                  phase_q <= PH_PROG;
                  cnt_q   <= 32'(PROG_CYC - 1);
               end
               else
               begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            PH_PROG:
            begin
               if (cnt_q == 32'h0000_0000)
               begin
                  phase_q <= PH_IDLE;
                  done_q  <= 1'b1;
               end
               else
               begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            default:
            begin
               // illegal code falls back to idle
               phase_q <= PH_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cell update at the end of each phase, data array target only
   always_ff @(posedge clk_i)
   begin
      if (!rst_i && ce_i && arr.to_array && cnt_q == 32'h0000_0000)
      begin
         if (phase_q == PH_ERASE)
         begin
            mem_q[arr.addr] <= ERASED_BYTE;
         end
         else if (phase_q == PH_PROG)
         begin
            mem_q[arr.addr] <= arr.wdata;
         end
      end
   end

endmodule // dnac_array

// *** rtl/dnac_top.sv ***
module dnac_top
   import dnac_pkg::*;
#(
   parameter int unsigned ERASE_TIME_NS = DEF_ERASE_TIME_NS,  // erase time
   parameter int unsigned PROG_TIME_NS  = DEF_PROG_TIME_NS    // program time
)
(
   // clock, resets, enable
   input  wire logic              CORE_CLK_I,
   input  wire logic              RST_I,
   input  wire logic              POR_I,
   input  wire logic              CE_I,
   // power-up timer status
   input  wire logic              PWRT_ACTIVE_I,
   // special function register port
   input  wire dnac_pkg::dnac_sel_t SFR_SEL_I,
   input  wire logic              SFR_WE_I,
   input  wire logic [7:0]        SFR_WDATA_I,
   output logic [7:0]             SFR_RDATA_O,
   // done flag in peripheral_flags_two bit 4
   input  wire logic              NVM_DONE_FLAG_CLR_I,
   output logic                   NVM_DONE_IRQ_FLAG_O,
   // write in progress
   output logic                   NVM_BUSY_O
);

   import dnac_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // derived timer counts
   localparam int unsigned ERASE_CYC = dnac_ns_to_cyc(ERASE_TIME_NS);
   localparam int unsigned PROG_CYC  = dnac_ns_to_cyc(PROG_TIME_NS);

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic       pgm_sel_q;     // program_space_select
   logic       cfg_sel_q;     // config_space_select
   logic       row_erase_q;   // row erase enable
   logic       abort_q;       // write_abort_flag
   logic       write_enable_gate_q;        // write_enable_gate
   logic       wr_q;          // write running
   logic       rd_q;          // read start, one cycle
   logic [7:0] addr_q;        // nvm_address_byte
   logic [7:0] data_q;        // nvm_data_byte
   logic       irq_q;         // nvm_done_irq_flag
   logic [7:0] rdata_q;       // register readback
   dnac_key_t  key_q;         // unlock sequence state

   ////////////////////////////////////////////////////////////////////////////
   // decode
   logic       rst_any;       // either reset
   logic       ctl_we;        // unlocked control write
   logic       wr_try;        // control write asks to launch
   logic       wr_ok;         // launch accepted
   logic       rd_ok;         // read accepted
   logic       done;          // array finished

   dnac_arr_if u_arr_if ();

   assign rst_any = RST_I | POR_I;
   // control writes are ignored while a write runs
   assign ctl_we  = SFR_WE_I && SFR_SEL_I == SEL_CTL && !wr_q;
   assign wr_try  = ctl_we && SFR_WDATA_I[CTL_WR];
   // launch only after the full key sequence with the gate already set
   assign wr_ok   = wr_try && key_q == KEY_ARMED
                    && write_enable_gate_q
                    && !PWRT_ACTIVE_I;
   // read refused when program or config space is selected
   assign rd_ok   = ctl_we && SFR_WDATA_I[CTL_RD] && !wr_try
                    && !SFR_WDATA_I[CTL_PGM_SEL]
                    && !SFR_WDATA_I[CTL_CFG_SEL];
   assign done    = u_arr_if.done;

   // array link
   assign u_arr_if.addr     = addr_q;
   assign u_arr_if.wdata    = data_q;
   assign u_arr_if.to_array = !pgm_sel_q && !cfg_sel_q;
   assign u_arr_if.start    = CE_I && wr_ok;

   dnac_array
   #(
      .ERASE_CYC (ERASE_CYC),
      .PROG_CYC  (PROG_CYC)
   )
   u_array
   (
      .clk_i (CORE_CLK_I),
      .rst_i (rst_any),
      .ce_i  (CE_I),
      .arr   (u_arr_if.arr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // unlock sequence tracker; any other register write breaks it
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst_any)
      begin
         key_q <= KEY_IDLE;
      end
      else if (CE_I && SFR_WE_I)
      begin
         if (SFR_SEL_I == SEL_KEY && SFR_WDATA_I == KEY_FIRST)
         begin
            key_q <= KEY_HALF;
         end
         else if (SFR_SEL_I == SEL_KEY && SFR_WDATA_I == KEY_SECOND
                  && key_q == KEY_HALF)
         begin
            key_q <= KEY_ARMED;
         end
         else
         begin
            // wrong key, launch attempt or other write consumes it
            key_q <= KEY_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // space select, row erase and write gate
   always_ff @(posedge CORE_CLK_I)
   begin
      if (POR_I)
      begin
         pgm_sel_q   <= RST_BIT;
         cfg_sel_q   <= RST_BIT;
         row_erase_q <= RST_BIT;
         write_enable_gate_q      <= RST_BIT;
      end
      else if (RST_I)
      begin
         // select bits survive a reset for tracing
         row_erase_q <= RST_BIT;
         write_enable_gate_q      <= RST_BIT;
      end
      else if (CE_I)
      begin
         if (done)
         begin
            row_erase_q <= RST_BIT;
         end
         else if (ctl_we && !wr_try)
         begin
            // a launch write leaves select bits as they are
            pgm_sel_q   <= SFR_WDATA_I[CTL_PGM_SEL];
            cfg_sel_q   <= SFR_WDATA_I[CTL_CFG_SEL];
            row_erase_q <= SFR_WDATA_I[CTL_ROW_ERASE];
            write_enable_gate_q      <= SFR_WDATA_I[CTL_WRITE_ENABLE_GATE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write and read start bits
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst_any)
      begin
         wr_q <= RST_BIT;
         rd_q <= RST_BIT;
      end
      else if (CE_I)
      begin
         rd_q <= rd_ok;
         if (done)
         begin
            wr_q <= RST_BIT;
         end
         else if (wr_ok)
         begin
            wr_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // abort flag: set at launch and on refused launch, kept over RST_I
   always_ff @(posedge CORE_CLK_I)
   begin
      if (POR_I)
      begin
         abort_q <= RST_BIT;
      end
      else if (!RST_I && CE_I)
      begin
         if (wr_try)
         begin
            abort_q <= 1'b1;
         end
         else if (done)
         begin
            abort_q <= RST_BIT;
         end
         else if (ctl_we)
         begin
            abort_q <= SFR_WDATA_I[CTL_ABORT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address register
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst_any)
      begin
         addr_q <= RST_BYTE;
      end
      else if (CE_I && SFR_WE_I && SFR_SEL_I == SEL_ADDR && !wr_q)
      begin
         addr_q <= SFR_WDATA_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data register: array read has priority over software write
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst_any)
      begin
         data_q <= RST_BYTE;
      end
      else if (CE_I)
      begin
         if (rd_q)
         begin
            data_q <= u_arr_if.rdata;
         end
         else if (SFR_WE_I && SFR_SEL_I == SEL_DATA && !wr_q)
         begin
            data_q <= SFR_WDATA_I;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // done flag: completion wins over a same-cycle clear
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst_any)
      begin
         irq_q <= RST_BIT;
      end
      else if (CE_I)
      begin
         if (done)
         begin
            irq_q <= 1'b1;
         end
         else if (NVM_DONE_FLAG_CLR_I)
         begin
            irq_q <= RST_BIT;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered readback of the selected register
   always_ff @(posedge CORE_CLK_I)
   begin
      if (rst_any)
      begin
         rdata_q <= RST_BYTE;
      end
      else if (CE_I)
      begin
         unique case (SFR_SEL_I)
            SEL_KEY:  rdata_q <= RST_BYTE;
            SEL_CTL:  rdata_q <= {pgm_sel_q, cfg_sel_q, 1'b0, row_erase_q,
                                  abort_q, write_enable_gate_q, wr_q, rd_q};
            SEL_DATA: rdata_q <= data_q;
            SEL_ADDR: rdata_q <= addr_q;
         endcase
      end
   end

   assign SFR_RDATA_O         = rdata_q;
   assign NVM_DONE_IRQ_FLAG_O = irq_q;
   assign NVM_BUSY_O          = wr_q;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking dnac_cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (rst_any);

   sequence s_key_first;
      CE_I && SFR_WE_I && SFR_SEL_I == SEL_KEY && SFR_WDATA_I == KEY_FIRST;
   endsequence

   sequence s_key_second;
      CE_I && SFR_WE_I && SFR_SEL_I == SEL_KEY && SFR_WDATA_I == KEY_SECOND;
   endsequence

   // an idle cycle between key writes keeps the sequence alive
   sequence s_no_write;
      !(CE_I && SFR_WE_I);
   endsequence

   AST_KEY_ARM: assert property (s_key_first ##1 s_no_write ##1
                                 s_key_second |=> key_q == KEY_ARMED)
      else $error("key sequence did not arm");

   AST_WR_NEEDS_KEY: assert property ($rose(wr_q) |->
                                      $past(key_q) == KEY_ARMED)
      else $error("write launched without key sequence");

   AST_WR_NEEDS_GATE: assert property ($rose(wr_q) |->
                                       $past(write_enable_gate_q) && !$past(PWRT_ACTIVE_I))
      else $error("write launched without gate or in power-up");

   AST_ABORT_AT_LAUNCH: assert property ($rose(wr_q) |->
                                         abort_q)
      else $error("abort flag not set at launch");

   AST_DONE_EFFECTS: assert property (CE_I && done |=>
                                      !wr_q && irq_q && !abort_q
                                      && !row_erase_q)
      else $error("completion effects missing");

   // a back-to-back read start may keep rd_q high one more cycle
   AST_RD_ONE_CYCLE: assert property (rd_q && CE_I |=>
                                      (!rd_q || $past(rd_ok))
                                      && data_q == $past(u_arr_if.rdata))
      else $error("read start not single cycle");

   AST_RD_REFUSED: assert property (rd_q |->
                                    !pgm_sel_q && !cfg_sel_q)
      else $error("read started in program or config space");

   // the done cycle is left out: registers unlock on the edge after it
   AST_LOCKED: assert property (wr_q && !done |=>
                                addr_q == $past(addr_q)
                                && pgm_sel_q == $past(pgm_sel_q)
                                && write_enable_gate_q == $past(write_enable_gate_q))
      else $error("register changed during write");

   AST_KEY_READS_ZERO: assert property (
                                        SFR_SEL_I == SEL_KEY && CE_I |=>
                                        SFR_RDATA_O == 8'h00)
      else $error("unlock port read nonzero");

endmodule // dnac_top

// *** dv/dnac_top_bench.sv ***
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the nvm access controller top
module dnac_top_bench
   import dnac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // short self-timer so a write lasts a handful of cycles
   localparam int unsigned ERASE_NS = 24;
   localparam int unsigned PROG_NS  = 16;
   localparam int          BUSY_CYC = (ERASE_NS + 7) / 8 + (PROG_NS + 7) / 8 + 1;

   logic       clk, rst, por, ce, pwrt, we, flag_clr;  // design inputs
   dnac_sel_t  sel;                                     // register select
   logic [7:0] wdata, rdata;                            // register port data
   logic       done_flag, busy;                         // status outputs
   int         bad_count, n_compared, n;                // counters
   logic [7:0] wa [2] = '{8'h00, 8'hFF};                // boundary addresses
   logic [7:0] wd [2] = '{8'h3C, 8'hC3};                // bytes to program

   dnac_top #(.ERASE_TIME_NS(ERASE_NS), .PROG_TIME_NS(PROG_NS)) i_dut
   (
      .CORE_CLK_I          (clk),
      .RST_I               (rst),
      .POR_I               (por),
      .CE_I                (ce),
      .PWRT_ACTIVE_I       (pwrt),
      .SFR_SEL_I           (sel),
      .SFR_WE_I            (we),
      .SFR_WDATA_I         (wdata),
      .SFR_RDATA_O         (rdata),
      .NVM_DONE_FLAG_CLR_I (flag_clr),
      .NVM_DONE_IRQ_FLAG_O (done_flag),
      .NVM_BUSY_O          (busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // 8 ns core clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // compare one byte, count and report
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // one register write, strobe high for one cycle
   task automatic wr(input dnac_sel_t s, input logic [7:0] d);
      @(negedge clk);
      sel   = s;
      wdata = d;
      we    = 1'b1;
      @(negedge clk);
      we    = 1'b0;
   endtask

   // select a register, compare its registered readback
   task automatic rd(input dnac_sel_t s, input logic [7:0] e);
      @(negedge clk);
      sel = s;
      we  = 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask

   // unlock keys followed by a control write
   task automatic launch(input logic [7:0] v);
      wr(SEL_KEY, KEY_FIRST);
      wr(SEL_KEY, KEY_SECOND);
      wr(SEL_CTL, v);
   endtask

   // count cycles with busy high, bounded
   task automatic wait_idle(output int c);
      c = 0;
      while (busy === 1'b1 && c < 100)
      begin
         c++;
         @(negedge clk);
      end
   endtask

   // check the done flag, then clear it by software
   task automatic flag_cycle();
      chk({7'h00, done_flag}, 8'h01);
      @(negedge clk);
      flag_clr = 1'b1;
      @(negedge clk);
      flag_clr = 1'b0;
      @(negedge clk);
      chk({7'h00, done_flag}, 8'h00);
   endtask

   // verdict, one place only
   task automatic conclude();
      $display("bad_count=%0d n_compared=%0d", bad_count, n_compared);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the tests need well under 1000 cycles
   initial
   begin
      #200000;
      bad_count++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      bad_count = 0; n_compared = 0;
      rst = 1'b1; por = 1'b1; ce = 1'b1; pwrt = 1'b0;
      we = 1'b0; flag_clr = 1'b0; sel = SEL_KEY; wdata = 8'h00;
      repeat (4) @(negedge clk);
      rst = 1'b0; por = 1'b0;
      rd(SEL_CTL, 8'h00);
      rd(SEL_KEY, 8'h00);
      // byte writes at both ends of the address range
      for (int i = 0; i < 2; i++)
      begin
         wr(SEL_DATA, wd[i]);
         wr(SEL_ADDR, wa[i]);
         wr(SEL_CTL, 8'h04);
         launch(8'h06);
         wait_idle(n);
         chk(8'(n), 8'(BUSY_CYC));
         rd(SEL_CTL, 8'h04);
         flag_cycle();
      end
      rd(SEL_KEY, 8'h00);
      // read both cells back
      for (int i = 0; i < 2; i++)
      begin
         wr(SEL_ADDR, wa[i]);
         wr(SEL_CTL, 8'h05);
         rd(SEL_DATA, wd[i]);
         rd(SEL_CTL, 8'h04);
      end
      wr(SEL_DATA, 8'h77);
      rd(SEL_DATA, 8'h77);
      // a write while the clock enable is low must be lost
      ce = 1'b0;
      wr(SEL_DATA, 8'h99);
      ce = 1'b1;
      rd(SEL_DATA, 8'h77);
      // read refused while program space is selected
      wr(SEL_ADDR, 8'h00);
      wr(SEL_CTL, 8'h81);
      rd(SEL_DATA, 8'h77);
      rd(SEL_CTL, 8'h80);
      // program space row erase, registers locked meanwhile
      wr(SEL_CTL, 8'h94);
      launch(8'h96);
      rd(SEL_CTL, 8'h9E);
      wr(SEL_DATA, 8'h11);
      wr(SEL_ADDR, 8'h11);
      wait_idle(n);
      rd(SEL_CTL, 8'h84);
      rd(SEL_DATA, 8'h77);
      rd(SEL_ADDR, 8'h00);
      flag_cycle();
      wr(SEL_CTL, 8'h01);
      rd(SEL_DATA, 8'h3C);
      // improper attempts never launch and leave the abort flag
      for (int k = 0; k < 4; k++)
      begin
         wr(SEL_CTL, (k == 0) ? 8'h00 : 8'h04);
         if (k == 0) launch(8'h06);
         if (k == 1) wr(SEL_KEY, KEY_SECOND);
         if (k == 1) wr(SEL_KEY, KEY_FIRST);
         if (k == 1) wr(SEL_CTL, 8'h06);
         if (k == 2) wr(SEL_KEY, KEY_FIRST);
         if (k == 2) wr(SEL_DATA, 8'h22);
         if (k == 2) wr(SEL_KEY, KEY_SECOND);
         if (k == 2) wr(SEL_CTL, 8'h06);
         pwrt = (k == 3);
         if (k == 3) launch(8'h06);
         pwrt = 1'b0;
         chk({7'h00, busy}, 8'h00);
         rd(SEL_CTL, (k == 0) ? 8'h08 : 8'h0C);
      end
      chk({7'h00, done_flag}, 8'h00);
      // reset in mid-write keeps the abort flag and the selects
      wr(SEL_CTL, 8'hC4);
      launch(8'hC6);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      rd(SEL_CTL, 8'hC8);
      chk({7'h00, busy}, 8'h00);
      // power-on reset clears every control bit, selects and abort flag included
      por = 1'b1;
      @(negedge clk);
      por = 1'b0;
      rd(SEL_CTL, 8'h00);
      conclude();
   end

endmodule // dnac_top_bench
